//--- monitor_control_config_regs.sv
// How it works
// - Powers up round robin idle; start bit 0 runs monitoring, clearing it stops.
// - Bits 1-2 pick shared inputs: 00 first/second analog, 10 external sensor.
// - Bit 3 makes the shared pin load trigger (0) or third analog input (1).
// - While that pin is analog, the third register's load-trigger bit is masked.
// - Bit 5 low enables the alert output, high disables it.
// - Bit 6 picks alert level: low active for 0, high active for 1.
// - Standby bit 7 set raises the standby control and stops monitoring; the alert pin stays as set.
// - Registers stay reachable in standby; clearing the bit resumes normal work.
// - Single-channel code in bits 0-2 picks supply, temperature or an input.
// - Code 010 converts external sensor or first input per input select.
// - Second register bit 4 picks round robin (0) or single channel (1).
// - Measurements average 16 samples unless second register bit 5 is set.
// - Bit 6 enables a 25 ms serial clock limit that releases the data line.
// - Writing 1 to second register bit 7 returns the three setup registers to defaults.
// - All three setup registers are 8-bit read/write at 0x18, 0x19 and 0x1a, reset zero.
module monitor_control_config_regs #(
   parameter int unsigned TIMEOUT_CYCLES = monitor_setup_pkg::TMO_CYCLES
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register bus.
   input wire monitor_setup_pkg::av_req_t av_req,
   output monitor_setup_pkg::av_rsp_t av_rsp,
   // Pins and device logic.
   input wire logic scl_pin,
   input wire logic alert_cond,
   output logic sda_release,
   output logic alert_o,
   output logic alert_oe_n,
   output logic irq,
   // Controls for the converter and outputs.
   output monitor_setup_pkg::ctrl_t ctrl
);
   import monitor_setup_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      logic [7:0] setup_first;
      logic [7:0] setup_second;
      logic [7:0] setup_third;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic wait_n;
      logic [31:0] rdata;
      logic scl_meta;
      logic scl_sync;
      logic [TMO_W-1:0] scl_low_cnt;
      logic sda_rel;
      logic alert_prev;
      logic alert_level;
      logic alert_off;
      logic irq_out;
      ctrl_t ctrl;
   } state_t;

   state_t state_q;
   state_t state_d;

   // Last count of the low-time limit, cut to the counter width.
   localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding shared by the next-state logic and the read path.

   // The input-select field reads with bit 1 as its first digit.
   function automatic logic [1:0] input_sel(input logic [7:0] first);
      return {first[B1_INSEL_A], first[B1_INSEL_B]};
   endfunction

   // Map a channel code to the physical source that is converted.
   function automatic src_t source_of(input logic [7:0] first, input logic [7:0] second);
      chan_code_t code;
      src_t src;
      code = chan_code_t'(second[B2_CHAN_LSB +: 3]);
      unique case (code)
         CH_SUPPLY: src = SRC_SUPPLY;
         CH_INT_TEMP: src = SRC_INT_TEMP;
         CH_EXT_OR_FIRST: src = (input_sel(first) == INSEL_EXT) ? SRC_EXT_TEMP : SRC_FIRST;
         CH_SECOND: src = SRC_SECOND;
         CH_THIRD: src = SRC_THIRD;
         CH_FOURTH: src = SRC_FOURTH;
         CH_RES_A, CH_RES_B: src = SRC_NONE;
      endcase
      return src;
   endfunction

   // Derive the converter controls from the three setup bytes.
   function automatic ctrl_t ctrl_of(input logic [7:0] first, input logic [7:0] second,
                                     input logic [7:0] third);
      ctrl_t c;
      c.standby = first[B1_STANDBY];
      c.monitor_run = first[B1_START] && !first[B1_STANDBY];
      c.input_select = input_sel(first);
      c.pin_analog = first[B1_PIN_ANALOG];
      c.load_trigger_enable = third[B3_LOAD_TRIG] && !first[B1_PIN_ANALOG];
      c.single_mode = second[B2_SINGLE];
      c.conv_source = source_of(first, second);
      c.avg_samples = second[B2_AVG_OFF] ? AVG_OFF_SAMPLES : AVG_ON_SAMPLES;
      return c;
   endfunction

   // Read mux; narrow registers sit in the low byte and the rest reads zero.
   function automatic logic [31:0] read_of(input state_t s, input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         IDX_SETUP_FIRST: v = s.setup_first;
         IDX_SETUP_SECOND: v = s.setup_second;
         IDX_SETUP_THIRD: v = s.setup_third;
         IDX_IRQ_STATUS: v = 8'(s.irq_status);
         IDX_IRQ_MASK: v = 8'(s.irq_mask);
         default: v = 8'h00;
      endcase
      return {24'h000000, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   // The whole block is one state record: this process builds the next copy.
   always_comb begin
      logic [IRQ_W-1:0] events;
      logic [IRQ_W-1:0] clear;
      logic take_write;
      events = '0;
      clear = '0;
      take_write = 1'b0;
      state_d = state_q;

      // Two flops on the serial clock pin before anything looks at it.
      state_d.scl_meta = scl_pin;
      state_d.scl_sync = state_q.scl_meta;

      // The low-time counter only runs while the limit is enabled; a stuck
      // clock then frees the data line until the clock goes high again.
      if (state_q.scl_sync || !state_q.setup_second[B2_TMO_EN]) begin
         state_d.scl_low_cnt = '0;
         state_d.sda_rel = 1'b0;
      end else if (state_q.scl_low_cnt == TMO_LAST) begin
         state_d.sda_rel = 1'b1;
      end else begin
         state_d.scl_low_cnt = state_q.scl_low_cnt + TMO_W'(1);
      end
      events[EV_TIMEOUT] = state_d.sda_rel && !state_q.sda_rel;

      // The alert condition comes from logic on this clock, so no synchroniser.
      state_d.alert_prev = alert_cond;
      events[EV_ALERT] = alert_cond && !state_q.alert_prev;

      // One wait cycle on every access: read data is prepared while the
      // request waits, and the write lands on the edge that ends the wait.
      // The bus keeps answering in standby, since nothing here is gated by it.
      if ((av_req.read || av_req.write) && state_q.wait_n) begin
         state_d.wait_n = 1'b0;
         state_d.rdata = read_of(state_q, av_req.address);
      end else begin
         state_d.wait_n = 1'b1;
         take_write = av_req.write && !state_q.wait_n && av_req.byteenable[0];
      end

      // Register writes; bit 4 of the first register is stored as written,
      // since software keeps it at zero.
      if (take_write) begin
         case (av_req.address)
            IDX_SETUP_FIRST: state_d.setup_first = av_req.writedata[7:0];
            IDX_SETUP_SECOND: begin
               if (av_req.writedata[B2_SW_RESET]) begin
                  state_d.setup_first = SETUP_RESET;
                  state_d.setup_second = SETUP_RESET;
                  state_d.setup_third = SETUP_RESET;
                  events[EV_SW_RESET] = 1'b1;
               end else begin
                  state_d.setup_second = av_req.writedata[7:0];
               end
            end
            IDX_SETUP_THIRD: state_d.setup_third = av_req.writedata[7:0];
            IDX_IRQ_STATUS: clear = av_req.writedata[IRQ_W-1:0];
            IDX_IRQ_MASK: state_d.irq_mask = av_req.writedata[IRQ_W-1:0];
            default: state_d.wait_n = 1'b1;
         endcase
      end

      // Sticky events; a new event beats a clear in the same cycle.
      state_d.irq_status = (state_q.irq_status & ~clear) | events;
      state_d.irq_out = |(state_d.irq_status & state_d.irq_mask);

      // Alert pin: driven at the chosen level, undriven while disabled.
      state_d.alert_off = state_d.setup_first[B1_ALERT_OFF];
      state_d.alert_level = alert_cond ~^ state_d.setup_first[B1_ALERT_HIGH];

      // Controls follow the new register contents so they are registered too.
      state_d.ctrl = ctrl_of(state_d.setup_first, state_d.setup_second, state_d.setup_third);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   // Everything clears to zero except wait_n, alert_level and avg_samples; zero is the power-up value of every register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= '0;
         state_q.wait_n <= 1'b1;
         state_q.alert_level <= 1'b1;
         state_q.ctrl.avg_samples <= AVG_ON_SAMPLES;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register.

   assign av_rsp.readdata = state_q.rdata;
   assign av_rsp.waitrequest = state_q.wait_n;
   assign sda_release = state_q.sda_rel;
   assign alert_o = state_q.alert_level;
   assign alert_oe_n = state_q.alert_off;
   assign irq = state_q.irq_out;
   assign ctrl = state_q.ctrl;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // A write that completes at this edge.
   sequence s_wr(logic [7:0] idx);
      av_req.write && !av_rsp.waitrequest && av_req.byteenable[0] && av_req.address == idx;
   endsequence

   // A request that is made while the device stands by.
   sequence s_req_standby;
      (av_req.read || av_req.write) && av_rsp.waitrequest && ctrl.standby;
   endsequence

   a_start_runs: assert property (s_wr(IDX_SETUP_FIRST) ##0 (av_req.writedata[0] && !av_req.writedata[7])
      |=> ctrl.monitor_run ##1 (ctrl.monitor_run || !av_rsp.waitrequest))
      else $error("start bit did not start monitoring");

   a_stop_halts: assert property (s_wr(IDX_SETUP_FIRST) ##0 !av_req.writedata[0]
      |=> !ctrl.monitor_run)
      else $error("clearing start bit did not stop monitoring");

   a_insel_follows: assert property (s_wr(IDX_SETUP_FIRST)
      |=> ctrl.input_select == {$past(av_req.writedata[1]), $past(av_req.writedata[2])})
      else $error("input select does not follow write");

   a_pin_masks: assert property (s_wr(IDX_SETUP_FIRST) ##0 av_req.writedata[3]
      |=> ctrl.pin_analog && !ctrl.load_trigger_enable)
      else $error("load trigger not masked in analog pin mode");

   a_alert_gate: assert property (s_wr(IDX_SETUP_FIRST)
      |=> alert_oe_n == $past(av_req.writedata[5]))
      else $error("alert enable does not follow write");

   a_alert_level: assert property (!alert_oe_n && $past(alert_cond) && $stable(state_q.setup_first)
      |-> alert_o == state_q.setup_first[B1_ALERT_HIGH])
      else $error("alert level wrong for polarity");

   a_standby_down: assert property (s_wr(IDX_SETUP_FIRST) ##0 av_req.writedata[7]
      |=> ctrl.standby && !ctrl.monitor_run)
      else $error("standby did not power down");

   a_standby_bus: assert property (s_req_standby |=> !av_rsp.waitrequest)
      else $error("bus stalled in standby");

   a_ext_source: assert property (ctrl.single_mode && state_q.setup_second[2:0] == CH_EXT_OR_FIRST
      |-> ctrl.conv_source == ((ctrl.input_select == INSEL_EXT) ? SRC_EXT_TEMP : SRC_FIRST))
      else $error("channel 010 source wrong");

   a_avg_count: assert property (s_wr(IDX_SETUP_SECOND) ##0 !av_req.writedata[7]
      |=> ctrl.avg_samples == ($past(av_req.writedata[5]) ? AVG_OFF_SAMPLES : AVG_ON_SAMPLES))
      else $error("averaging count wrong");

   a_tmo_quiet: assert property (!state_q.setup_second[B2_TMO_EN] |=> !sda_release)
      else $error("data line released with limit off");

   a_tmo_reach: assert property ($rose(sda_release)
      |-> $past(state_q.scl_low_cnt) == TMO_LAST && !$past(state_q.scl_sync))
      else $error("data line released before limit");

   a_sw_reset: assert property (s_wr(IDX_SETUP_SECOND) ##0 av_req.writedata[7]
      |=> state_q.setup_first == SETUP_RESET && state_q.setup_second == SETUP_RESET
          && state_q.irq_status[EV_SW_RESET])
      else $error("software reset left a register set");

   // The reset bit never stays stored, so every answered read of it shows zero.
   a_reset_reads0: assert property (av_req.read && av_req.address == IDX_SETUP_SECOND && !av_rsp.waitrequest
      |-> !av_rsp.readdata[B2_SW_RESET])
      else $error("reset bit reads back set");

   // Helper: an alert edge seen this cycle.
   logic events_pending;
   assign events_pending = alert_cond && !state_q.alert_prev;

   // A new alert edge must survive a clear of the same bit in the same cycle.
   a_set_wins: assert property (events_pending |=> state_q.irq_status[EV_ALERT])
      else $error("alert event lost");

endmodule

//--- monitor_control_config_regs_tb.sv
module monitor_control_config_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import monitor_setup_pkg::*;

   // A short timeout keeps the serial clock test brief.
   localparam int TMO = 20;

   logic clk;
   logic rst;
   av_req_t av_req;
   av_rsp_t av_rsp;
   logic scl_pin;
   logic alert_cond;
   logic sda_release;
   logic alert_o;
   logic alert_oe_n;
   logic irq;
   ctrl_t ctrl;
   int fail_count;
   int checks_done;
   logic [7:0] rd;

   monitor_control_config_regs #(.TIMEOUT_CYCLES(TMO)) dut_u (
      .clk(clk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp), .scl_pin(scl_pin), .alert_cond(alert_cond),
      .sda_release(sda_release), .alert_o(alert_o), .alert_oe_n(alert_oe_n), .irq(irq), .ctrl(ctrl));

   ////////////////////////////////////////////////////////////////////////////////
   // Comparisons, one per kind of result.
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic check_src(input string what, input src_t exp, input src_t got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Avalon master: the request stands until waitrequest is sampled low.
   // No own limit on the wait: a bus that never answers is caught by the watchdog.
   task automatic bus_access(input logic wr, input logic [7:0] idx, input logic [7:0] data, input logic [3:0] be);
      @(posedge clk);
      av_req <= '{read: !wr, write: wr, address: idx, writedata: {24'h0, data}, byteenable: be};
      do begin
         @(posedge clk);
      end while (av_rsp.waitrequest !== 1'b0);
      rd = av_rsp.readdata[7:0];
      av_req <= '0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      bus_access(1'b1, idx, data, 4'h1);
   endtask

   task automatic rdreg(input logic [7:0] idx);
      bus_access(1'b0, idx, 8'h00, 4'h0);
   endtask

   // Controls change on the same edge as a completed write, so two edges are enough.
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_reset();
      rdreg(IDX_SETUP_FIRST); check_byte("first reset", SETUP_RESET, rd);
      rdreg(IDX_SETUP_SECOND); check_byte("second reset", SETUP_RESET, rd);
      check_bit("idle run", 1'b0, ctrl.monitor_run);
      check_bit("round robin", 1'b0, ctrl.single_mode);
      check_byte("averaging", {3'h0, AVG_ON_SAMPLES}, {3'h0, ctrl.avg_samples});
      check_bit("alert driven", 1'b0, alert_oe_n);
      check_bit("alert idle high", 1'b1, alert_o);
      $display("test reset done");
   endtask

   task automatic t_first();
      wr(IDX_SETUP_FIRST, 8'h01); settle();
      check_bit("run started", 1'b1, ctrl.monitor_run);
      rdreg(IDX_SETUP_FIRST); check_byte("first readback", 8'h01, rd);
      wr(IDX_SETUP_FIRST, 8'h0a); settle();
      check_bit("run stopped", 1'b0, ctrl.monitor_run);
      check_byte("input select", {6'h0, INSEL_EXT}, {6'h0, ctrl.input_select});
      check_bit("pin analog", 1'b1, ctrl.pin_analog);
      wr(IDX_SETUP_THIRD, 8'h08); settle();
      check_bit("trigger masked", 1'b0, ctrl.load_trigger_enable);
      wr(IDX_SETUP_FIRST, 8'h00); settle();
      check_bit("trigger restored", 1'b1, ctrl.load_trigger_enable);
      check_bit("pin trigger", 1'b0, ctrl.pin_analog);
      check_byte("input select first", 8'h00, {6'h0, ctrl.input_select});
      wr(IDX_SETUP_THIRD, 8'h00);
      $display("test first register done");
   endtask

   task automatic t_alert();
      wr(IDX_IRQ_MASK, 8'h01);
      @(posedge clk) alert_cond <= 1'b1;
      settle(); @(posedge clk); #1;
      check_bit("alert low active", 1'b0, alert_o);
      check_bit("irq alert", 1'b1, irq);
      wr(IDX_SETUP_FIRST, 8'h40); settle();
      check_bit("alert high active", 1'b1, alert_o);
      @(posedge clk) alert_cond <= 1'b0;
      settle(); @(posedge clk); #1;
      check_bit("alert high idle", 1'b0, alert_o);
      rdreg(IDX_IRQ_STATUS); check_byte("status alert", 8'h01, rd);
      wr(IDX_IRQ_STATUS, 8'h01); settle();
      check_bit("irq cleared", 1'b0, irq);
      wr(IDX_IRQ_MASK, 8'h00);
      @(posedge clk) alert_cond <= 1'b1;
      settle();
      check_bit("irq masked", 1'b0, irq);
      wr(IDX_SETUP_FIRST, 8'h60); settle();
      check_bit("alert disabled", 1'b1, alert_oe_n);
      @(posedge clk) alert_cond <= 1'b0;
      wr(IDX_SETUP_FIRST, 8'h00); wr(IDX_IRQ_STATUS, 8'h01); settle();
      check_bit("alert enabled", 1'b0, alert_oe_n);
      $display("test alert done");
   endtask

   task automatic t_standby();
      wr(IDX_SETUP_FIRST, 8'h81); settle();
      check_bit("standby on", 1'b1, ctrl.standby);
      check_bit("standby halts run", 1'b0, ctrl.monitor_run);
      wr(IDX_SETUP_SECOND, 8'h20);
      rdreg(IDX_SETUP_SECOND); check_byte("standby access", 8'h20, rd);
      wr(IDX_SETUP_FIRST, 8'h01); settle();
      check_bit("standby off", 1'b0, ctrl.standby);
      check_bit("run resumes", 1'b1, ctrl.monitor_run);
      wr(IDX_SETUP_FIRST, 8'h00); wr(IDX_SETUP_SECOND, 8'h00);
      $display("test standby done");
   endtask

   task automatic t_single();
      src_t exp;
      for (int ext = 0; ext < 2; ext++) begin
         wr(IDX_SETUP_FIRST, ext ? 8'h02 : 8'h00);
         for (int code = 0; code < 8; code++) begin
            case (code)
               0: exp = SRC_SUPPLY;
               1: exp = SRC_INT_TEMP;
               2: exp = ext ? SRC_EXT_TEMP : SRC_FIRST;
               3: exp = SRC_SECOND;
               4: exp = SRC_THIRD;
               5: exp = SRC_FOURTH;
               default: exp = SRC_NONE;
            endcase
            wr(IDX_SETUP_SECOND, 8'h10 | 8'(code)); settle();
            check_src("source", exp, ctrl.conv_source);
            check_bit("single mode", 1'b1, ctrl.single_mode);
         end
      end
      wr(IDX_SETUP_SECOND, 8'h20); settle();
      check_bit("round robin back", 1'b0, ctrl.single_mode);
      check_byte("no averaging", {3'h0, AVG_OFF_SAMPLES}, {3'h0, ctrl.avg_samples});
      wr(IDX_SETUP_FIRST, 8'h00); wr(IDX_SETUP_SECOND, 8'h00);
      $display("test single channel done");
   endtask

   task automatic t_timeout();
      int n;
      @(posedge clk) scl_pin <= 1'b0;
      repeat (TMO + 10) @(posedge clk);
      #1 check_bit("timeout disabled", 1'b0, sda_release);
      @(posedge clk) scl_pin <= 1'b1;
      wr(IDX_SETUP_SECOND, 8'h40); wr(IDX_IRQ_MASK, 8'h02); settle();
      @(posedge clk) scl_pin <= 1'b0;
      n = 0;
      while (sda_release !== 1'b1 && n < 2 * TMO + 20) begin
         @(posedge clk);
         #1 n++;
      end
      check_bit("release late enough", 1'b1, n >= TMO && n <= TMO + 6);
      check_bit("irq timeout", 1'b1, irq);
      @(posedge clk) scl_pin <= 1'b1;
      repeat (5) @(posedge clk);
      #1 check_bit("release ends", 1'b0, sda_release);
      rdreg(IDX_IRQ_STATUS); check_byte("status timeout", 8'h02, rd & 8'h02);
      wr(IDX_IRQ_STATUS, 8'h02); wr(IDX_IRQ_MASK, 8'h00); wr(IDX_SETUP_SECOND, 8'h00);
      $display("test timeout done");
   endtask

   task automatic t_swreset();
      // Reserved bit 4 of the first register is written as zero.
      wr(IDX_SETUP_FIRST, 8'h6b); wr(IDX_SETUP_SECOND, 8'h37); wr(IDX_SETUP_THIRD, 8'h08);
      wr(IDX_SETUP_SECOND, 8'h80); settle();
      rdreg(IDX_SETUP_FIRST); check_byte("first after reset", 8'h00, rd);
      rdreg(IDX_SETUP_SECOND); check_byte("reset bit clear", 8'h00, rd);
      rdreg(IDX_SETUP_THIRD); check_byte("third after reset", 8'h00, rd);
      check_bit("single cleared", 1'b0, ctrl.single_mode);
      rdreg(IDX_IRQ_STATUS); check_byte("status reset", 8'h04, rd & 8'h04);
      wr(IDX_IRQ_STATUS, 8'h04);
      $display("test software reset done");
   endtask

   task automatic t_refused();
      wr(8'h05, 8'hff);
      rdreg(8'h05); check_byte("unmapped read", 8'h00, rd);
      bus_access(1'b1, IDX_SETUP_FIRST, 8'hef, 4'h0);
      rdreg(IDX_SETUP_FIRST); check_byte("byteenable off", 8'h00, rd);
      $display("test refused access done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run.
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Clock at 40 MHz.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // The tests take some 330 cycles; the watchdog allows 30000, about ninety times that.
   initial begin
      #(25 * 30000);
      fail_count++;
      final_report();
   end

   // Main sequence.
   initial begin
      rst = 1'b1;
      av_req = '0;
      scl_pin = 1'b1;
      alert_cond = 1'b0;
      fail_count = 0;
      checks_done = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_first();
      t_alert();
      t_standby();
      t_single();
      t_timeout();
      t_swreset();
      t_refused();
      final_report();
   end
endmodule

//--- monitor_setup_pkg.sv
package monitor_setup_pkg;

   // Register indexes; the byte address is four times the index.
   localparam logic [7:0] IDX_SETUP_FIRST = 8'h18;
   localparam logic [7:0] IDX_SETUP_SECOND = 8'h19;
   localparam logic [7:0] IDX_SETUP_THIRD = 8'h1a;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h1c;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h1d;

   // Field positions of the first setup register.
   localparam int B1_START = 0;
   localparam int B1_INSEL_A = 1;
   localparam int B1_INSEL_B = 2;
   localparam int B1_PIN_ANALOG = 3;
   localparam int B1_ALERT_OFF = 5;
   localparam int B1_ALERT_HIGH = 6;
   localparam int B1_STANDBY = 7;

   // Field positions of the second and third setup registers.
   localparam int B2_CHAN_LSB = 0;
   localparam int B2_SINGLE = 4;
   localparam int B2_AVG_OFF = 5;
   localparam int B2_TMO_EN = 6;
   localparam int B2_SW_RESET = 7;
   localparam int B3_LOAD_TRIG = 3;

   // Interrupt status and mask bits.
   localparam int IRQ_W = 3;
   localparam int EV_ALERT = 0;
   localparam int EV_TIMEOUT = 1;
   localparam int EV_SW_RESET = 2;

   // Reset values and field codes.
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [1:0] INSEL_EXT = 2'h2;
   localparam logic [4:0] AVG_ON_SAMPLES = 5'h10;
   localparam logic [4:0] AVG_OFF_SAMPLES = 5'h01;

   // Serial clock low-time limit.
   localparam int TMO_MS = 25;
   localparam int CLK_HZ = 40000000;
   localparam int TMO_CYCLES = TMO_MS * (CLK_HZ / 1000);
   localparam int TMO_W = 24;

   // Channel codes written by software.
   typedef enum logic [2:0] {
      CH_SUPPLY = 3'b000, CH_INT_TEMP = 3'b001, CH_EXT_OR_FIRST = 3'b010, CH_SECOND = 3'b011,
      CH_THIRD = 3'b100, CH_FOURTH = 3'b101, CH_RES_A = 3'b110, CH_RES_B = 3'b111
   } chan_code_t;

   // Physical source actually converted.
   typedef enum logic [2:0] {
      SRC_SUPPLY = 3'b000, SRC_INT_TEMP = 3'b001, SRC_FIRST = 3'b010, SRC_SECOND = 3'b011,
      SRC_THIRD = 3'b100, SRC_FOURTH = 3'b101, SRC_EXT_TEMP = 3'b110, SRC_NONE = 3'b111
   } src_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } av_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } av_rsp_t;

   typedef struct packed {
      logic monitor_run;
      logic standby;
      logic [1:0] input_select;
      logic pin_analog;
      logic load_trigger_enable;
      logic single_mode;
      src_t conv_source;
      logic [4:0] avg_samples;
   } ctrl_t;

endpackage
